/* src/bft_regs.vh */
// Register map, field positions, reset values and timing counts of the breaker failure timers.
// Function
// - One pick-up starts both delay counters together.
// - Second-coil enable, default yes, gates that stage.
// - Second-coil output after second-coil delay, 5 ms steps.
// - Failure output after failure delay, 5 ms steps.
// - Current-only: pick-up from currents, trip ignored.
// - Current-only: counters clear when currents drop.
// - Current-and-trip: counters halt until trip active.
// - Current-and-trip: clear on current drop or trip release.
// - Current-or-trip: pick-up on either condition.
// - Current-or-trip: outputs after delays on either.
// - Current-or-trip: clear only when both gone.
// - Second-coil disabled: only failure counter runs.
// - Second-coil output on its own pin.
// - Current flags release below 97 percent of threshold.
// - Block at pick-up raises blocked, stops counters.
`ifndef BFT_REGS_VH
`define BFT_REGS_VH

`define BFT_ADDR_W          4
`define BFT_REG_CTRL        4'h0
`define BFT_REG_RETR_DLY    4'h1
`define BFT_REG_FAIL_DLY    4'h2
`define BFT_REG_PH_THR      4'h3
`define BFT_REG_RES_THR     4'h4
`define BFT_REG_STATUS      4'h5
`define BFT_REG_IRQ_STAT    4'h6
`define BFT_REG_IRQ_MASK    4'h7

`define BFT_CTRL_MODE_LSB   0
`define BFT_CTRL_RETR_EN    2
`define BFT_CTRL_RESET      32'h0000_0004
`define BFT_MODE_CUR        2'h0
`define BFT_MODE_CUR_AND    2'h1
`define BFT_MODE_CUR_OR     2'h2

`define BFT_RETR_DLY_RESET  16'h0014
`define BFT_FAIL_DLY_RESET  16'h0028
`define BFT_PH_THR_RESET    16'h0014
`define BFT_RES_THR_RESET   16'h04B0

`define BFT_RELEASE_NUM     97
`define BFT_RELEASE_DEN     100

`define BFT_TICK_NS         5000000
`define BFT_CLK_NS          10
`define BFT_TICK_CYCLES     (`BFT_TICK_NS / `BFT_CLK_NS)

`define BFT_EV_START        0
`define BFT_EV_RETR         1
`define BFT_EV_FAIL         2
`define BFT_EV_BLOCK        3
`define BFT_NUM_EV          4

`endif

/* src/bft_pickup_flag.v */
// Current pick-up comparator with hysteresis release.
`timescale 1ns/1ps
module bft_pickup_flag #(
    parameter W = 16
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire [W-1:0] meas_in,
    input  wire [W-1:0] thr_in,
    output reg          flag_out
);
    // Release point is the threshold scaled to 97 percent, widened to avoid overflow.
    wire [W+7:0] meas_scaled = {8'h00, meas_in} * 8'h64;
    wire [W+7:0] thr_scaled  = {8'h00, thr_in} * 8'h61;

    // Set above threshold, hold until the current falls below the release point.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_out <= 1'b0;
        end else if (meas_in > thr_in) begin
            flag_out <= 1'b1;
        end else if (meas_scaled < thr_scaled) begin
            flag_out <= 1'b0;
        end
    end
endmodule

/* src/bft_delay_timer.v */
// Tick-driven delay counter that fires once a start condition lasted its delay.
`timescale 1ns/1ps
module bft_delay_timer #(
    parameter W = 16
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire         clear_in,
    input  wire         run_in,
    input  wire         tick_in,
    input  wire [W-1:0] delay_in,
    output reg          done_out
);
    reg [W-1:0] count_r;

    // Clear wins over counting; the count saturates at the delay so it cannot wrap.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r  <= {W{1'b0}};
            done_out <= 1'b0;
        end else if (clear_in) begin
            count_r  <= {W{1'b0}};
            done_out <= 1'b0;
        end else begin
            if (run_in && tick_in && count_r < delay_in) begin
                count_r <= count_r + 1'b1;
            end
            done_out <= run_in && (count_r >= delay_in);
        end
    end
endmodule

/* src/bft_top.v */
// Breaker failure timers: pick-up logic, retrip and failure delays, registers and interrupt.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bft_regs.vh"
module bft_top #(
    parameter TICK_CYCLES = `BFT_TICK_CYCLES,
    parameter CUR_W       = 16
) (
    input  wire                   CLK_IN,
    input  wire                   RST_IN,
    input  wire [`BFT_ADDR_W-1:0] ADDR_IN,
    input  wire [31:0]            WDATA_IN,
    input  wire                   WR_IN,
    input  wire                   RD_IN,
    output reg  [31:0]            RDATA_OUT,
    input  wire [CUR_W-1:0]       PHASE_CUR_IN,
    input  wire [CUR_W-1:0]       RESID_CUR_IN,
    input  wire                   PRIMARY_TRIP_IN,
    input  wire                   BLOCK_IN,
    output reg                    SECOND_COIL_OUT,
    output reg                    BREAKER_FAILURE_OUTPUT_OUT,
    output reg                    BLOCKED_OUT,
    output reg                    IRQ_OUT
);
    reg  [1:0]        mode_r;
    reg               retr_en_r;
    reg  [15:0]       second_coil_delay_r;
    reg  [15:0]       fail_delay_r;
    reg  [CUR_W-1:0]  phase_pickup_threshold_r;
    reg  [CUR_W-1:0]  residual_pickup_threshold_r;
    reg  [31:0]       tick_cnt_r;
    reg               tick_r;
    reg  [2:0]        trip_sync_r;
    reg  [2:0]        blk_sync_r;
    reg               trip_r;
    reg               blk_r;
    reg               pickup_d_r;
    reg               blocked_r;
    reg               retr_d_r;
    reg               fail_d_r;
    reg  [`BFT_NUM_EV-1:0] irq_stat_r;
    reg  [`BFT_NUM_EV-1:0] irq_mask_r;
    reg  [`BFT_NUM_EV-1:0] ev_nxt;
    reg               pickup;
    reg               run;
    wire              ph_flag;
    wire              res_flag;
    wire              retr_done;
    wire              fail_done;
    wire              cur_flag = ph_flag | res_flag;
    wire              wr_ctrl  = WR_IN && (ADDR_IN == `BFT_REG_CTRL);

    // Current comparators with their own release hysteresis.
    bft_pickup_flag #(.W(CUR_W)) u_ph (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .meas_in  (PHASE_CUR_IN),
        .thr_in   (phase_pickup_threshold_r),
        .flag_out (ph_flag)
    );
    bft_pickup_flag #(.W(CUR_W)) u_res (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .meas_in  (RESID_CUR_IN),
        .thr_in   (residual_pickup_threshold_r),
        .flag_out (res_flag)
    );

    // Pins cross from outside; a change is taken once the last two stages agree.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            trip_sync_r <= 3'h0;
            blk_sync_r  <= 3'h0;
            trip_r      <= 1'b0;
            blk_r       <= 1'b0;
        end else begin
            trip_sync_r <= {trip_sync_r[1:0], PRIMARY_TRIP_IN};
            blk_sync_r  <= {blk_sync_r[1:0], BLOCK_IN};
            if (trip_sync_r[2] == trip_sync_r[1]) begin
                trip_r <= trip_sync_r[2];
            end
            if (blk_sync_r[2] == blk_sync_r[1]) begin
                blk_r <= blk_sync_r[2];
            end
        end
    end

    // Free running 5 ms tick paces both delay counters.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r     <= 1'b0;
        end
    end

    // Pick-up and run condition per criterion; halting only applies to current-and-trip.
    always @* begin
        case (mode_r)
            `BFT_MODE_CUR_AND: begin
                pickup = cur_flag;
                run    = cur_flag & trip_r;
            end
            `BFT_MODE_CUR_OR: begin
                pickup = cur_flag | trip_r;
                run    = pickup;
            end
            default: begin
                pickup = cur_flag;
                run    = cur_flag;
            end
        endcase
    end

    // Block latched at pick-up; a block after start also resets the counters.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pickup_d_r <= 1'b0;
            blocked_r  <= 1'b0;
        end else begin
            pickup_d_r <= pickup;
            if (!pickup) begin
                blocked_r <= 1'b0;
            end else if (blk_r) begin
                blocked_r <= 1'b1;
            end
        end
    end

    wire active = run & ~blocked_r & ~blk_r;

    // Both timers share one start so they begin in the same cycle.
    bft_delay_timer #(.W(16)) u_retr (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .clear_in (~active | ~retr_en_r),
        .run_in   (active),
        .tick_in  (tick_r),
        .delay_in (second_coil_delay_r),
        .done_out (retr_done)
    );
    bft_delay_timer #(.W(16)) u_fail (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .clear_in (~active),
        .run_in   (active),
        .tick_in  (tick_r),
        .delay_in (fail_delay_r),
        .done_out (fail_done)
    );

    // A start in the first cycle of a pick-up, and rising edges of retrip, failure and blocked, become events.
    always @* begin
        ev_nxt = {`BFT_NUM_EV{1'b0}};
        ev_nxt[`BFT_EV_START] = active & ~pickup_d_r;
        ev_nxt[`BFT_EV_RETR]  = retr_done & ~retr_d_r;
        ev_nxt[`BFT_EV_FAIL]  = fail_done & ~fail_d_r;
        ev_nxt[`BFT_EV_BLOCK] = pickup & blk_r & ~blocked_r;
    end

    // Settings and interrupt registers; a new event wins over a write-one clear.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mode_r                      <= `BFT_MODE_CUR;
            retr_en_r                   <= 1'b1;
            second_coil_delay_r         <= `BFT_RETR_DLY_RESET;
            fail_delay_r                <= `BFT_FAIL_DLY_RESET;
            phase_pickup_threshold_r    <= `BFT_PH_THR_RESET;
            residual_pickup_threshold_r <= `BFT_RES_THR_RESET;
            irq_stat_r                  <= {`BFT_NUM_EV{1'b0}};
            irq_mask_r                  <= {`BFT_NUM_EV{1'b0}};
            retr_d_r                    <= 1'b0;
            fail_d_r                    <= 1'b0;
        end else begin
            retr_d_r <= retr_done;
            fail_d_r <= fail_done;
            if (wr_ctrl) begin
                mode_r    <= WDATA_IN[`BFT_CTRL_MODE_LSB+1:`BFT_CTRL_MODE_LSB];
                retr_en_r <= WDATA_IN[`BFT_CTRL_RETR_EN];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_RETR_DLY) begin
                second_coil_delay_r <= WDATA_IN[15:0];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_FAIL_DLY) begin
                fail_delay_r <= WDATA_IN[15:0];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_PH_THR) begin
                phase_pickup_threshold_r <= WDATA_IN[CUR_W-1:0];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_RES_THR) begin
                residual_pickup_threshold_r <= WDATA_IN[CUR_W-1:0];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_IRQ_MASK) begin
                irq_mask_r <= WDATA_IN[`BFT_NUM_EV-1:0];
            end
            if (WR_IN && ADDR_IN == `BFT_REG_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~WDATA_IN[`BFT_NUM_EV-1:0]) | ev_nxt;
            end else begin
                irq_stat_r <= irq_stat_r | ev_nxt;
            end
        end
    end

    // Outputs come from flip-flops; the second coil has its own pin apart from the trip.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SECOND_COIL_OUT            <= 1'b0;
            BREAKER_FAILURE_OUTPUT_OUT <= 1'b0;
            BLOCKED_OUT                <= 1'b0;
            IRQ_OUT                    <= 1'b0;
        end else begin
            SECOND_COIL_OUT            <= retr_done & retr_en_r;
            BREAKER_FAILURE_OUTPUT_OUT <= fail_done;
            BLOCKED_OUT                <= blocked_r;
            IRQ_OUT                    <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read data stand one cycle after the strobe; unmapped addresses read zero.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 32'h0;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `BFT_REG_CTRL:     RDATA_OUT <= {29'h0, retr_en_r, mode_r};
                `BFT_REG_RETR_DLY: RDATA_OUT <= {16'h0, second_coil_delay_r};
                `BFT_REG_FAIL_DLY: RDATA_OUT <= {16'h0, fail_delay_r};
                `BFT_REG_PH_THR:   RDATA_OUT <= {{(32-CUR_W){1'b0}}, phase_pickup_threshold_r};
                `BFT_REG_RES_THR:  RDATA_OUT <= {{(32-CUR_W){1'b0}}, residual_pickup_threshold_r};
                `BFT_REG_STATUS:   RDATA_OUT <= {26'h0, trip_r, cur_flag, blocked_r,
                                                 fail_done, retr_done, active};
                `BFT_REG_IRQ_STAT: RDATA_OUT <= {28'h0, irq_stat_r};
                `BFT_REG_IRQ_MASK: RDATA_OUT <= {28'h0, irq_mask_r};
                default:           RDATA_OUT <= 32'h0;
            endcase
        end else begin
            RDATA_OUT <= 32'h0;
        end
    end
endmodule

/* tb/bft_top_assertions.sv */
// Port-level checker of the breaker failure timers.
`timescale 1ns/1ps
module bft_checker (
    input wire        CLK_IN,
    input wire        RST_IN,
    input wire [3:0]  ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire        WR_IN,
    input wire        RD_IN,
    input wire [31:0] RDATA_OUT,
    input wire [15:0] PHASE_CUR_IN,
    input wire [15:0] RESID_CUR_IN,
    input wire        PRIMARY_TRIP_IN,
    input wire        SECOND_COIL_OUT,
    input wire        BREAKER_FAILURE_OUTPUT_OUT,
    input wire        BLOCKED_OUT,
    input wire        IRQ_OUT
);
    reg  mask_zero_r;
    reg  retr_en_r;
    wire sc = SECOND_COIL_OUT;
    wire bf = BREAKER_FAILURE_OUTPUT_OUT;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Mirrors of the mask and retrip enable writes, reset to the register defaults.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_zero_r <= 1'b1;
            retr_en_r   <= 1'b1;
        end else if (WR_IN && ADDR_IN == 4'h7) begin
            mask_zero_r <= (WDATA_IN[3:0] == 4'h0);
        end else if (WR_IN && ADDR_IN == 4'h0) begin
            retr_en_r <= WDATA_IN[2];
        end
    end
    property p_rst; $fell(RST_IN) |-> !sc && !bf && !BLOCKED_OUT; endproperty
    a_rst: assert property (p_rst) else $error("output high after reset");
    property p_idle; !$past(RD_IN) |-> RDATA_OUT == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside its cycle");
    property p_unmap; RD_IN && ADDR_IN[3] |=> RDATA_OUT == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_dly; WR_IN && ADDR_IN == 4'h1 ##1 RD_IN && ADDR_IN == 4'h1
        |=> RDATA_OUT == ($past(WDATA_IN, 2) & 32'h0000FFFF); endproperty
    a_dly: assert property (p_dly) else $error("delay readback wrong");
    property p_clear; (PHASE_CUR_IN == 16'h0 && RESID_CUR_IN == 16'h0 && !PRIMARY_TRIP_IN) [*8]
        |=> !sc && !bf; endproperty
    a_clear: assert property (p_clear) else $error("outputs stay without pickup");
    property p_blk; BLOCKED_OUT [*3] |-> !sc && !bf; endproperty
    a_blk: assert property (p_blk) else $error("output while blocked");
    property p_irq; mask_zero_r && $past(mask_zero_r) |-> !IRQ_OUT; endproperty
    a_irq: assert property (p_irq) else $error("interrupt with all sources masked");
    property p_noretr; !retr_en_r && !$past(retr_en_r, 3) |-> !sc; endproperty
    a_noretr: assert property (p_noretr) else $error("retrip while disabled");
endmodule
bind bft_top bft_checker u_chk (.CLK_IN, .RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
    .RDATA_OUT, .PHASE_CUR_IN, .RESID_CUR_IN, .PRIMARY_TRIP_IN, .SECOND_COIL_OUT,
    .BREAKER_FAILURE_OUTPUT_OUT, .BLOCKED_OUT, .IRQ_OUT);

/* tb/bft_breaker_model.sv */
// Breaker and feeder model: a working coil opens the breaker and cuts the fault current.
`timescale 1ns/1ps
module bft_breaker_model #(
    parameter OPEN_CYC = 8
) (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [15:0] fault_in,
    input  wire        trip_in,
    input  wire        coil2_in,
    input  wire        bf_in,
    input  wire [1:0]  works_in,
    output wire [15:0] cur_out
);
    integer cnt;
    reg     open_r;
    // The feeder breaker always opens on the failure output; each coil only when it works.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt    <= 0;
            open_r <= 1'b0;
        end else if (fault_in == 16'h0) begin
            cnt    <= 0;
            open_r <= 1'b0;
        end else if ((trip_in & works_in[0]) | (coil2_in & works_in[1]) | bf_in) begin
            cnt <= cnt + 1;
            if (cnt >= OPEN_CYC) open_r <= 1'b1;
        end
    end
    // An open breaker carries no current at all.
    assign cur_out = open_r ? 16'h0 : fault_in;
endmodule

/* tb/bft_top_test.sv */
// Self-checking bench of the breaker failure timers against a breaker model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
    err_count = err_count + 1; $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module bft_top_test;
    localparam TICK = 10;
    localparam ALL  = 32'hFFFFFFFF;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         wr_s = 1'b0, rd_s = 1'b0, trip = 1'b0, blk = 1'b0;
    reg  [15:0] fault = 16'h0, resid = 16'h0;
    reg  [1:0]  works = 2'b00;
    wire [31:0] rdata;
    wire [15:0] cur;
    wire        sc, bf, blocked, irq;
    integer     err_count = 0, n_compared = 0, cyc = 0, t_sc, t_bf;
    bft_top #(.TICK_CYCLES(TICK)) dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .PHASE_CUR_IN(cur),
        .RESID_CUR_IN(resid), .PRIMARY_TRIP_IN(trip), .BLOCK_IN(blk), .SECOND_COIL_OUT(sc),
        .BREAKER_FAILURE_OUTPUT_OUT(bf), .BLOCKED_OUT(blocked), .IRQ_OUT(irq));
    bft_breaker_model brk (.clk_in(clk), .rst_in(rst), .fault_in(fault), .trip_in(trip),
        .coil2_in(sc), .bf_in(bf), .works_in(works), .cur_out(cur));
    task tally_and_finish;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            addr  <= a;
            wdata <= d;
            wr_s  <= 1'b1;
            @(posedge clk);
            wr_s  <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] m, input [31:0] e);
        begin
            addr <= a;
            rd_s <= 1'b1;
            @(posedge clk);
            rd_s <= 1'b0;
            #1;
            `CHK(rdata & m, e)
        end
    endtask
    // Records the first cycle at which each output is high, or -1 if it never rose.
    task watch(input integer lim);
        integer i;
        begin
            t_sc = -1;
            t_bf = -1;
            for (i = 0; i < lim; i = i + 1) begin
                @(posedge clk);
                #1;
                if (sc === 1'b1 && t_sc < 0) t_sc = i;
                if (bf === 1'b1 && t_bf < 0) t_bf = i;
            end
        end
    endtask
    task quiet;
        begin
            fault <= 16'h0;
            resid <= 16'h0;
            trip  <= 1'b0;
            blk   <= 1'b0;
            works <= 2'b00;
            repeat (12) @(posedge clk);
        end
    endtask
    // The tick phase is free, so a delay of d ticks may land anywhere in one extra tick.
    function win(input integer t, input integer d);
        win = t >= (d - 1) * TICK && t <= d * TICK + 15;
    endfunction
    initial begin
        forever #5 clk = ~clk;
    end
    // Cuts a hang short well above the expected run of about 880 cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, ALL, 32'h4);
        rd(4'h1, ALL, 32'h14);
        rd(4'h2, ALL, 32'h28);
        rd(4'h3, ALL, 32'h14);
        rd(4'h4, ALL, 32'h4B0);
        rd(4'h9, ALL, 32'h0);
        wr(4'h1, 32'h3);
        rd(4'h1, ALL, 32'h3);
        wr(4'h2, 32'h6);
        wr(4'h7, 32'hF);
        fault <= 16'h0100;
        watch(130);
        `CHK(win(t_sc, 3) && win(t_bf, 6), 1'b1)
        `CHK(sc | bf, 1'b0)
        `CHK(irq, 1'b1)
        rd(4'h6, ALL, 32'h7);
        wr(4'h6, 32'h7);
        rd(4'h6, ALL, 32'h0);
        `CHK(irq, 1'b0)
        quiet;
        wr(4'h0, 32'h5);
        fault <= 16'h0100;
        watch(100);
        `CHK(t_sc == -1 && t_bf == -1, 1'b1)
        trip <= 1'b1;
        watch(45);
        `CHK(win(t_sc, 3) && t_bf == -1, 1'b1)
        trip <= 1'b0;
        watch(10);
        `CHK(sc, 1'b0)
        quiet;
        wr(4'h0, 32'h6);
        trip <= 1'b1;
        watch(45);
        `CHK(win(t_sc, 3), 1'b1)
        resid <= 16'h04B1;
        trip  <= 1'b0;
        watch(40);
        `CHK(t_sc == 0 && win(t_bf + 45, 6), 1'b1)
        resid <= 16'h0;
        watch(10);
        `CHK(sc | bf, 1'b0)
        quiet;
        wr(4'h0, 32'h0);
        fault <= 16'h0100;
        watch(80);
        `CHK(t_sc == -1 && win(t_bf, 6), 1'b1)
        quiet;
        wr(4'h0, 32'h4);
        works <= 2'b10;
        fault <= 16'h0100;
        watch(100);
        `CHK(win(t_sc, 3) && t_bf == -1, 1'b1)
        quiet;
        wr(4'h3, 32'h64);
        fault <= 16'h0065;
        repeat (4) @(posedge clk);
        rd(4'h5, 32'h10, 32'h10);
        fault <= 16'h0061;
        repeat (4) @(posedge clk);
        rd(4'h5, 32'h10, 32'h10);
        fault <= 16'h0060;
        repeat (4) @(posedge clk);
        rd(4'h5, 32'h10, 32'h0);
        quiet;
        wr(4'h6, 32'hF);
        // The block pin is synchronised, so it must settle before pick-up to count as present.
        blk   <= 1'b1;
        repeat (8) @(posedge clk);
        fault <= 16'h0100;
        watch(80);
        `CHK(t_sc == -1 && t_bf == -1 && blocked === 1'b1, 1'b1)
        rd(4'h6, 32'h8, 32'h8);
        `CHK(irq, 1'b1)
        wr(4'h7, 32'h7);
        rd(4'h7, ALL, 32'h7);
        `CHK(irq, 1'b0)
        wr(4'h6, 32'hF);
        wr(4'h7, 32'hF);
        rd(4'h6, ALL, 32'h0);
        `CHK(irq, 1'b0)
        quiet;
        fault <= 16'h0100;
        watch(8);
        blk <= 1'b1;
        watch(80);
        `CHK(t_sc == -1 && t_bf == -1, 1'b1)
        quiet;
        tally_and_finish;
    end
endmodule
